// *** psbsp_pkg.sv ***
// psbsp_pkg: shared constants and types of the pipelined burst sram port.
// assumes one system clock; included by every design file of the block.
package psbsp_pkg;

   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 18;
   localparam int DATA_W = 36;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int WORDS = 262144;
   localparam int BURST_W = 2;

   // ----------------------------------------------------------------
   // pipeline and buffering
   // ----------------------------------------------------------------
   // edges between command capture and the start of its data slot
   localparam int DATA_OFFSET = 2;
   localparam int WBUF_DEPTH = 8;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] RDATA_RST = 36'h0_0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;
   localparam logic [BURST_W-1:0] BCNT_RST = 2'h0;
   localparam logic [LANES-1:0] LANE_RST = 4'h0;
   localparam logic DRIVE_RST = 1'b0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_IDLE = 3'h1,
      OP_READ = 3'h2,
      OP_WRITE = 3'h4
   } psbsp_op_t;

   typedef struct packed {
      psbsp_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] lane_en;
   } psbsp_cmd_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] lane_en;
      logic [DATA_W-1:0] data;
   } psbsp_went_t;

   localparam int WENT_W = $bits(psbsp_went_t);

   localparam psbsp_cmd_t CMD_RST = '{op: OP_IDLE, addr: ADDR_RST, lane_en: LANE_RST};

endpackage

// *** psbsp_port.sv ***
// psbsp_port: pipelined burst sram port with posted write buffer.
// assumes the memory controller runs on sys_clk and drives all inputs
// synchronously; the bidirectional data wire is resolved outside.

// ----------------------------------------------------------------
// write buffer
// ----------------------------------------------------------------
module psbsp_fifo
   import psbsp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // contents, oldest at index 0
   output logic [$clog2(DEPTH+1)-1:0] level,
   output logic [DEPTH-1:0][WIDTH-1:0] peek
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [PW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign in_ready = (cnt_r != CW'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign level = cnt_r;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      mem_nxt = mem_r;
      rd_nxt = rd_r;
      wr_nxt = wr_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wr_r] = in_data;
         wr_nxt = (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
         rd_nxt = (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         peek[i] = mem_r[PW'((32'(rd_r) + i) % DEPTH)];
      end
   end

   always_ff @(posedge sys_clk) begin
      mem_r <= mem_nxt;
      if (rst) begin
         rd_r <= '0;
         wr_r <= '0;
         cnt_r <= '0;
      end else begin
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// ----------------------------------------------------------------
// sram port
// ----------------------------------------------------------------
module psbsp_port
   import psbsp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // command
   input wire logic [ADDR_W-1:0] address,
   input wire logic burst_advance,
   input wire logic write_enable_n,
   input wire logic [LANES-1:0] byte_lane_write_n,
   input wire logic clock_qualify_n,
   // selects and output control
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic output_enable_n,
   // configuration
   input wire logic burst_interleaved,
   // data wire
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe_n,
   // status
   output logic write_buffer_ready
);

   // ----------------------------------------------------------------
   // storage and state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] array_mem [WORDS];

   psbsp_cmd_t s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt;
   logic [ADDR_W-1:0] base_r, base_nxt;
   logic [BURST_W-1:0] bcnt_r, bcnt_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic drive_r, drive_nxt;
   logic freeze, selected;

   psbsp_went_t push_ent, drain_ent;
   logic push_valid, push_ready, drain_valid, drain_ready;
   logic [$clog2(WBUF_DEPTH+1)-1:0] wb_level;
   logic [WBUF_DEPTH-1:0][WENT_W-1:0] wb_peek;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] burst_addr(
      input logic [ADDR_W-1:0] base,
      input logic [BURST_W-1:0] cnt,
      input logic order_il
   );
      logic [BURST_W-1:0] low;
      low = order_il ? (base[BURST_W-1:0] ^ cnt) : (base[BURST_W-1:0] + cnt);
      return {base[ADDR_W-1:BURST_W], low};
   endfunction

   // later writes overwrite only the lanes they enable
   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] upd,
      input logic [LANES-1:0] lane_en
   );
      logic [DATA_W-1:0] res;
      res = old;
      for (int l = 0; l < LANES; l++) begin
         if (lane_en[l]) begin
            res[l*LANE_W +: LANE_W] = upd[l*LANE_W +: LANE_W];
         end
      end
      return res;
   endfunction

   // a suspended edge behaves as if the previous cycle continued
   assign freeze = clock_qualify_n;
   assign selected = !chip_select_first_n && chip_select_second
      && !chip_select_third_n;

   // ----------------------------------------------------------------
   // command capture and burst sequencing
   // ----------------------------------------------------------------
   always_comb begin
      s1_nxt = s1_r;
      base_nxt = base_r;
      bcnt_nxt = bcnt_r;
      if (!freeze) begin
         if (burst_advance) begin
            // continue the running burst with its captured op type
            bcnt_nxt = bcnt_r + 1'b1;
            s1_nxt.addr = burst_addr(base_r, bcnt_nxt, burst_interleaved);
            s1_nxt.lane_en = ~byte_lane_write_n;
         end else begin
            base_nxt = address;
            bcnt_nxt = BCNT_RST;
            s1_nxt.addr = address;
            s1_nxt.lane_en = ~byte_lane_write_n;
            if (!selected) begin
               s1_nxt.op = OP_IDLE;
            end else if (write_enable_n) begin
               s1_nxt.op = OP_READ;
            end else begin
               s1_nxt.op = OP_WRITE;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // pipeline and read path
   // ----------------------------------------------------------------
   // read data is the array word patched by every posted write still in
   // the buffer and by the write whose data is on the wire right now
   always_comb begin
      logic [DATA_W-1:0] word;
      psbsp_went_t ent;
      word = array_mem[s2_r.addr];
      ent = '0;
      s2_nxt = s2_r;
      s3_nxt = s3_r;
      rdata_nxt = rdata_r;
      drive_nxt = drive_r;
      for (int i = 0; i < WBUF_DEPTH; i++) begin
         ent = psbsp_went_t'(wb_peek[i]);
         if (i < 32'(wb_level) && ent.addr == s2_r.addr) begin
            word = merge(word, ent.data, ent.lane_en);
         end
      end
      if (s3_r.op == OP_WRITE && s3_r.addr == s2_r.addr) begin
         word = merge(word, dq_in, s3_r.lane_en);
      end
      if (!freeze) begin
         s2_nxt = s1_r;
         s3_nxt = s2_r;
         unique case (s2_r.op)
            OP_READ: begin
               rdata_nxt = word;
               drive_nxt = 1'b1;
            end
            OP_WRITE: begin
               drive_nxt = 1'b0;
            end
            OP_IDLE: begin
               drive_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s1_r <= CMD_RST;
         s2_r <= CMD_RST;
         s3_r <= CMD_RST;
         base_r <= ADDR_RST;
         bcnt_r <= BCNT_RST;
         rdata_r <= RDATA_RST;
         drive_r <= DRIVE_RST;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         base_r <= base_nxt;
         bcnt_r <= bcnt_nxt;
         rdata_r <= rdata_nxt;
         drive_r <= drive_nxt;
      end
   end

   // ----------------------------------------------------------------
   // write path
   // ----------------------------------------------------------------
   // write data is taken in the slot of its command, one edge after the
   // read slot would have launched, so no turnaround is needed
   always_comb begin
      push_ent.addr = s3_r.addr;
      push_ent.lane_en = s3_r.lane_en;
      push_ent.data = dq_in;
      push_valid = !freeze && s3_r.op == OP_WRITE;
      // the array has one port; a read in flight takes it first, which
      // is what lets the buffer fill under long read streams
      drain_ready = !freeze && s2_r.op != OP_READ;
   end

   psbsp_fifo #(
      .WIDTH(WENT_W),
      .DEPTH(WBUF_DEPTH)
   ) u_wbuf (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_ent),
      .out_valid(drain_valid),
      .out_ready(drain_ready),
      .out_data(drain_ent),
      .level(wb_level),
      .peek(wb_peek)
   );

   // the write retires only on an edge with clock_qualify_n low and no read in s2_r
   always_ff @(posedge sys_clk) begin
      if (drain_valid && drain_ready) begin
         array_mem[drain_ent.addr] <= merge(array_mem[drain_ent.addr],
            drain_ent.data, drain_ent.lane_en);
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign dq_out = rdata_r;
   // output enable acts without waiting for an edge
   assign dq_oe_n = output_enable_n || !drive_r;
   // a write arriving while this is low is dropped
   assign write_buffer_ready = push_ready;

endmodule

// *** psbsp_port_assertions.sv ***
// psbsp_port_assertions: pin timing checks of the sram port.
// assumes one clock and synchronous rst; bound to every psbsp_port.
module psbsp_port_checker
   import psbsp_pkg::*;
(
   // clock
   input wire logic sys_clk,
   input wire logic rst,
   // command
   input wire logic burst_advance,
   input wire logic write_enable_n,
   input wire logic clock_qualify_n,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic output_enable_n,
   // outputs
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic write_buffer_ready
);
   logic sel, go;
   assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
   assign go = !clock_qualify_n;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff rst;
   sequence ld(logic s, logic w);
      go && !burst_advance && sel == s && write_enable_n == w;
   endsequence
   AST_RESET_OUT: assert property ($fell(rst) |-> dq_oe_n && dq_out == RDATA_RST)
      else $error("outputs not idle after reset");
   AST_RESET_READY: assert property ($fell(rst) |-> write_buffer_ready)
      else $error("write buffer not ready after reset");
   AST_OE_ASYNC: assert property (output_enable_n |-> dq_oe_n)
      else $error("drivers on while output enable is off");
   AST_FREEZE: assert property (clock_qualify_n |=> $stable(dq_out))
      else $error("read data moved on a frozen edge");
   AST_UNSEL_IDLE: assert property (go && !burst_advance && !sel ##1 go ##1 go |=> dq_oe_n)
      else $error("unselected slot drove the wire");
   AST_WRITE_HIZ: assert property (ld(1'b1, 1'b0) ##1 go ##1 go |=> dq_oe_n)
      else $error("wire driven in a write data slot");
   AST_READ_SLOT: assert property (ld(1'b1, 1'b1) ##1 go[*2] |=> output_enable_n || !dq_oe_n)
      else $error("read slot not driven two edges after command");
   AST_READ_STANDS: assert property (ld(1'b1, 1'b1) ##1 ld(1'b0, 1'b1) ##1 go[*2] |=> dq_oe_n)
      else $error("read data held past its slot");
   COV_READ: cover property (ld(1'b1, 1'b1) ##1 go[*2]);
   COV_FREEZE: cover property (clock_qualify_n[*2]);
   COV_BURST: cover property (go && burst_advance && sel);
endmodule

bind psbsp_port psbsp_port_checker i_chk (.sys_clk(sys_clk), .rst(rst),
   .burst_advance(burst_advance), .write_enable_n(write_enable_n),
   .clock_qualify_n(clock_qualify_n), .chip_select_first_n(chip_select_first_n),
   .chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
   .output_enable_n(output_enable_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
   .write_buffer_ready(write_buffer_ready));

// *** psbsp_ctrl_model.sv ***
// psbsp_ctrl_model: memory controller end of the data wire.
// assumes the bench drives the command pins and hands write data with each command.
module psbsp_ctrl_model
   import psbsp_pkg::*;
(
   // clock
   input wire logic sys_clk,
   input wire logic rst,
   // command as driven to the port
   input wire logic clock_qualify_n,
   input wire logic burst_advance,
   input wire logic write_enable_n,
   input wire logic [2:0] sel_act,
   input wire logic [DATA_W-1:0] wdata,
   // wire
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic dq_oe_n,
   output logic [DATA_W-1:0] dq_in
);
   logic wr_r, s1_r, s2_r, drv_r, wr_now;
   logic [DATA_W-1:0] d1_r, d2_r, dd_r, last_r;
   // an advance keeps the op of its load
   assign wr_now = burst_advance ? wr_r : (&sel_act && !write_enable_n);
   // a released wire shows the inverse of its last level, never a stale copy
   assign dq_in = drv_r ? dd_r : (!dq_oe_n ? dq_out : ~last_r);
   always @(posedge sys_clk) begin
      last_r <= rst ? '0 : dq_in;
      if (rst) begin
         {wr_r, s1_r, s2_r, drv_r} <= 4'h0;
      end else if (!clock_qualify_n) begin
         wr_r <= wr_now;
         {s1_r, d1_r} <= {wr_now, wdata};
         {s2_r, d2_r} <= {s1_r, d1_r};
         {drv_r, dd_r} <= {s2_r, d2_r};
      end
   end
endmodule

// *** psbsp_port_tb.sv ***
// psbsp_port_tb: directed scenarios for the pipelined sram port.
// assumes psbsp_ctrl_model drives the wire; inputs move 1 ns after each edge.
module psbsp_port_tb
   import psbsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // command codes: {freeze, idle, advance, write_enable_n}
   localparam logic [3:0] WR = 4'h0, RD = 4'h1, WRB = 4'h2, RDB = 4'h3, IDL = 4'h5, FRZ = 4'hD;
   localparam logic [ADDR_W-1:0] A = 18'h3_FFFF, B = 18'h0_0005;
   localparam logic [DATA_W-1:0] D1 = 36'hA_5A5A_5A5A, D2 = 36'h1_2345_6789;
   logic sys_clk = 1'b0, rst = 1'b1, burst_advance = 1'b0, write_enable_n = 1'b1;
   logic clock_qualify_n = 1'b0, output_enable_n = 1'b0, burst_interleaved = 1'b0;
   logic dq_oe_n, write_buffer_ready;
   logic [ADDR_W-1:0] address = '0;
   logic [LANES-1:0] byte_lane_write_n = '0;
   logic [2:0] sel_v = 3'h7, sel_eff = 3'h0;
   logic [DATA_W-1:0] wdata = '0, dq_in, dq_out;
   int err_total = 0, compares = 0;
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   psbsp_port i_dut (.sys_clk(sys_clk), .rst(rst), .address(address),
      .burst_advance(burst_advance), .write_enable_n(write_enable_n),
      .byte_lane_write_n(byte_lane_write_n), .clock_qualify_n(clock_qualify_n),
      .chip_select_first_n(~sel_eff[0]), .chip_select_second(sel_eff[1]),
      .chip_select_third_n(~sel_eff[2]), .output_enable_n(output_enable_n),
      .burst_interleaved(burst_interleaved), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .write_buffer_ready(write_buffer_ready));
   psbsp_ctrl_model i_ctrl (.sys_clk(sys_clk), .rst(rst), .clock_qualify_n(clock_qualify_n),
      .burst_advance(burst_advance), .write_enable_n(write_enable_n), .sel_act(sel_eff),
      .wdata(wdata), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
   task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // chk 1: read slot with data e, chk 2: wire released
   task automatic issue(input logic [3:0] c, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input int chk, input logic [DATA_W-1:0] e);
      {clock_qualify_n, burst_advance, write_enable_n} = {c[3], c[1], c[0]};
      sel_eff = c[2] ? 3'h0 : sel_v;
      address = a;
      wdata = d;
      @(posedge sys_clk);
      #1;
      if (chk == 1) check("dq_out", dq_out, e);
      if (chk > 0) check("dq_oe_n", {35'h0, dq_oe_n}, {35'h0, chk == 2});
   endtask
   task automatic t_rw();
      issue(WR, A, D1, 0, '0);
      issue(WR, B, D2, 0, '0);
      byte_lane_write_n = 4'hE;
      issue(WR, B, {DATA_W{1'b1}}, 2, '0);
      byte_lane_write_n = 4'h0;
      issue(RD, A, '0, 2, '0);
      issue(RD, B, '0, 2, '0);
      issue(IDL, A, '0, 1, D1);
      issue(IDL, A, '0, 1, {D2[35:9], 9'h1FF});
      issue(IDL, A, '0, 2, '0);
      check("ready", {35'h0, write_buffer_ready}, 36'h1);
      $display("test rw done");
   endtask
   task automatic t_freeze();
      issue(RD, A, '0, 0, '0);
      issue(IDL, A, '0, 0, '0);
      issue(FRZ, A, '0, 2, '0);
      issue(FRZ, A, '0, 2, '0);
      issue(IDL, A, '0, 1, D1);
      output_enable_n = 1'b1;
      issue(FRZ, A, '0, 2, '0);
      output_enable_n = 1'b0;
      issue(FRZ, A, '0, 1, D1);
      issue(IDL, A, '0, 2, '0);
      $display("test freeze done");
   endtask
   task automatic t_sel();
      for (int k = 0; k < 3; k++) begin
         sel_v = 3'h7 ^ (3'h1 << k);
         issue(RD, A, '0, 0, '0);
         sel_v = 3'h7;
         issue(IDL, A, '0, 0, '0);
         issue(IDL, A, '0, 2, '0);
      end
      $display("test select done");
   endtask
   task automatic t_burst();
      logic [ADDR_W-1:0] a;
      for (int k = 0; k < 7; k++) begin
         a = 18'h0_0100 + 18'(k);
         issue(k == 0 ? WR : (k < 4 ? WRB : IDL), a, {18'h0_0000, a}, 0, '0);
      end
      for (int m = 0; m < 2; m++) begin
         burst_interleaved = m[0];
         for (int k = 0; k < 6; k++) begin
            a = 18'h0_0100 | (m == 1 ? 18'((1 ^ (k - 2)) & 3) : 18'((k - 1) & 3));
            issue(k == 0 ? RD : (k < 4 ? RDB : IDL), 18'h0_0101, '0, k > 1, {18'h0_0000, a});
         end
      end
      $display("test burst done");
   endtask
   task automatic close_out();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      check("reset", {dq_oe_n, write_buffer_ready, dq_out[33:0]}, {2'h3, 34'h0});
      check("reset dq_out", dq_out, RDATA_RST);
      t_rw();
      t_freeze();
      t_sel();
      t_burst();
      close_out();
   end
   initial begin
      #200000;
      err_total++;
      close_out();
   end
endmodule
